// File: rtl/pbcb_bank.sv
// What this block does
// - Registers reached only by index, indirectly
// - Decode indexes 0-6, 16-18, 26, 27, 29-31
// - Bit 15 starts soft reset, self-clears
// - Normal mode after soft reset completes
// - Kept fields survive only soft reset
// - Speed bit 13, duplex bit 8
// - Bit 12 enables auto-negotiation, overrides manual
// - Bit 11 selects general power down
// - Bit 9 restarts auto-negotiation, self-clears
module pbcb_bank #(
  parameter logic [15:0] IDENT_HIGH_VAL = 16'h1234,  // Arbitrary identity value
  parameter logic [15:0] IDENT_LOW_VAL  = 16'h5678,  // Arbitrary identity value
  parameter int unsigned SOFT_CYCLES    = pbcb_pkg::SOFT_RST_CYCLES
) (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        mgmt_wr_in,
  input  wire logic        mgmt_rd_in,
  input  wire logic [4:0]  mgmt_idx_in,
  input  wire logic [15:0] mgmt_wr_data_in,
  input  wire logic        link_up_in,
  input  wire logic        an_done_in,
  input  wire logic        an_speed_100_in,
  input  wire logic        an_full_duplex_in,
  input  wire logic [15:0] an_partner_in,
  output logic      [15:0] mgmt_rd_data_out,
  output logic             mgmt_rd_valid_out,
  output logic             mgmt_unmapped_out,
  output logic             soft_rst_busy_out,
  output logic             an_restart_out,
  output logic             an_enable_out,
  output logic             speed_100_out,
  output logic             full_duplex_out,
  output logic             loopback_out,
  output logic             power_down_out,
  output logic             col_test_out
);
  import pbcb_pkg::*;

  // Control register fields
  logic        loopback_q;                    // Loopback selected
  logic        speed_q;                       // Manual speed, 1 = 100 Mbps
  logic        an_en_q;                       // Auto-negotiation enabled
  logic        pdn_q;                         // General power down
  logic        restart_q;                     // Restart request, self-clearing
  logic        duplex_q;                      // Manual duplex, 1 = full
  logic        col_test_q;                    // Collision signal test
  // Soft reset sequencing
  logic        srst_q;                        // Soft reset in progress
  logic [15:0] srst_cnt_q;                    // Cycles left in soft reset
  logic        soft_clr;                      // One-cycle end of soft reset
  logic [15:0] srst_len_q;                    // Cycles soft reset has run, checker helper
  // Status and decode
  logic        link_ll_q;                     // Latched-low link status
  logic        ctrl_wr;                       // Write to basic control
  logic        idx_hit;                       // Index is decoded
  logic [15:0] ctrl_view;                     // Basic control as read
  logic [15:0] stat_view;                     // Basic status as read
  logic [15:0] rd_mux;                        // Selected read value
  logic [15:0] adv_q;                         // Advertisement storage
  logic [15:0] xover_q;                       // Energy detect crossover time
  logic [15:0] mode_q;                        // Mode control storage
  logic [15:0] smodes_q;                      // Special modes storage
  logic [15:0] imask_q;                       // Interrupt mask storage
  logic [15:0] pspec_q;                       // PHY special control storage
  logic [15:0] idh_q;                         // Identifier high storage
  logic [15:0] idl_q;                         // Identifier low storage

  // Writes are refused while soft reset runs; the sequence owns the bank then
  assign ctrl_wr  = mgmt_wr_in && !srst_q && (mgmt_idx_in == IDX_BASIC_CTRL);
  assign soft_clr = srst_q && (srst_cnt_q == 16'h0000);

  // Index decode for every register the bank answers
  always_comb begin
    unique case (mgmt_idx_in)
      IDX_BASIC_CTRL, IDX_BASIC_STATUS, IDX_IDENT_HIGH, IDX_IDENT_LOW,
      IDX_AN_ADVERTISE, IDX_AN_PARTNER, IDX_AN_EXPANSION,
      IDX_ENERGY_XOVER, IDX_MODE_CTRL_STAT, IDX_SPECIAL_MODES,
      IDX_SYMBOL_ERRORS, IDX_SPECIAL_INDIC, IDX_IRQ_SOURCE,
      IDX_IRQ_MASK, IDX_PHY_SPECIAL: idx_hit = 1'b1;
      default:                       idx_hit = 1'b0;
    endcase
  end

  // Storage registers; special modes and identifiers survive soft reset
  pbcb_reg16 #(.RST_VAL(ADVERTISE_RST_VAL), .WMASK(ADVERTISE_WMASK), .KEEP_SOFT(1'b0))
    u_adv (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .soft_clr_in(soft_clr),
           .wr_in(mgmt_wr_in && !srst_q && mgmt_idx_in == IDX_AN_ADVERTISE),
           .wr_data_in(mgmt_wr_data_in), .value_out(adv_q));
  pbcb_reg16 #(.RST_VAL(ZERO_RST_VAL), .WMASK(FULL_WMASK), .KEEP_SOFT(1'b0))
    u_xover (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .soft_clr_in(soft_clr),
             .wr_in(mgmt_wr_in && !srst_q && mgmt_idx_in == IDX_ENERGY_XOVER),
             .wr_data_in(mgmt_wr_data_in), .value_out(xover_q));
  pbcb_reg16 #(.RST_VAL(ZERO_RST_VAL), .WMASK(FULL_WMASK), .KEEP_SOFT(1'b0))
    u_mode (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .soft_clr_in(soft_clr),
            .wr_in(mgmt_wr_in && !srst_q && mgmt_idx_in == IDX_MODE_CTRL_STAT),
            .wr_data_in(mgmt_wr_data_in), .value_out(mode_q));
  // Kept through soft reset: cleared only by the hard reset
  pbcb_reg16 #(.RST_VAL(ZERO_RST_VAL), .WMASK(FULL_WMASK), .KEEP_SOFT(1'b1))
    u_smodes (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .soft_clr_in(soft_clr),
              .wr_in(mgmt_wr_in && !srst_q && mgmt_idx_in == IDX_SPECIAL_MODES),
              .wr_data_in(mgmt_wr_data_in), .value_out(smodes_q));
  pbcb_reg16 #(.RST_VAL(ZERO_RST_VAL), .WMASK(FULL_WMASK), .KEEP_SOFT(1'b0))
    u_imask (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .soft_clr_in(soft_clr),
             .wr_in(mgmt_wr_in && !srst_q && mgmt_idx_in == IDX_IRQ_MASK),
             .wr_data_in(mgmt_wr_data_in), .value_out(imask_q));
  pbcb_reg16 #(.RST_VAL(ZERO_RST_VAL), .WMASK(FULL_WMASK), .KEEP_SOFT(1'b0))
    u_pspec (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .soft_clr_in(soft_clr),
             .wr_in(mgmt_wr_in && !srst_q && mgmt_idx_in == IDX_PHY_SPECIAL),
             .wr_data_in(mgmt_wr_data_in), .value_out(pspec_q));
  pbcb_reg16 #(.RST_VAL(IDENT_HIGH_VAL), .WMASK(FULL_WMASK), .KEEP_SOFT(1'b1))
    u_idh (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .soft_clr_in(soft_clr),
           .wr_in(mgmt_wr_in && !srst_q && mgmt_idx_in == IDX_IDENT_HIGH),
           .wr_data_in(mgmt_wr_data_in), .value_out(idh_q));
  pbcb_reg16 #(.RST_VAL(IDENT_LOW_VAL), .WMASK(FULL_WMASK), .KEEP_SOFT(1'b1))
    u_idl (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .soft_clr_in(soft_clr),
           .wr_in(mgmt_wr_in && !srst_q && mgmt_idx_in == IDX_IDENT_LOW),
           .wr_data_in(mgmt_wr_data_in), .value_out(idl_q));

  // Soft reset sequencer: bit 15 starts it, end of count clears it
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      srst_q     <= 1'b0;
      srst_cnt_q <= 16'h0000;
    end else if (ctrl_wr && mgmt_wr_data_in[CTRL_SOFT_RST_BIT]) begin
      srst_q     <= 1'b1;
      srst_cnt_q <= 16'(SOFT_CYCLES - 1);
    end else if (soft_clr) begin
      // Bit drops by itself once the sequence ends
      srst_q     <= 1'b0;
    end else if (srst_q) begin
      srst_cnt_q <= srst_cnt_q - 16'h0001;
    end
  end

  // Mode fields of basic control; defaults again after soft reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || soft_clr) begin
      // Back to normal mode: no loopback, no power down
      loopback_q <= CTRL_RST_VAL[CTRL_LOOPBACK_BIT];
      speed_q    <= CTRL_RST_VAL[CTRL_SPEED_BIT];
      an_en_q    <= CTRL_RST_VAL[CTRL_AN_EN_BIT];
      pdn_q      <= CTRL_RST_VAL[CTRL_PWR_DOWN_BIT];
      duplex_q   <= CTRL_RST_VAL[CTRL_DUPLEX_BIT];
      col_test_q <= CTRL_RST_VAL[CTRL_COL_TEST_BIT];
    end else if (ctrl_wr && !mgmt_wr_data_in[CTRL_SOFT_RST_BIT]) begin
      // A soft reset write carries nothing else, so other bits are not taken
      loopback_q <= mgmt_wr_data_in[CTRL_LOOPBACK_BIT];
      speed_q    <= mgmt_wr_data_in[CTRL_SPEED_BIT];
      an_en_q    <= mgmt_wr_data_in[CTRL_AN_EN_BIT];
      pdn_q      <= mgmt_wr_data_in[CTRL_PWR_DOWN_BIT];
      duplex_q   <= mgmt_wr_data_in[CTRL_DUPLEX_BIT];
      col_test_q <= mgmt_wr_data_in[CTRL_COL_TEST_BIT];
    end
  end

  // Restart request stands one cycle; a fresh write of one always wins
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= ctrl_wr && mgmt_wr_data_in[CTRL_AN_RESTART_BIT];
    end
  end

  // Link status latches low until read, so a short drop is never missed
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      link_ll_q <= 1'b0;
    end else if (!link_up_in) begin
      link_ll_q <= 1'b0;
    end else if (mgmt_rd_in && mgmt_idx_in == IDX_BASIC_STATUS) begin
      link_ll_q <= 1'b1;
    end else if (!link_ll_q && !mgmt_rd_in) begin
      link_ll_q <= link_ll_q;
    end
  end

  // Register views as seen by the management path; reserved bits read zero
  always_comb begin
    ctrl_view = 16'h0000;
    ctrl_view[CTRL_SOFT_RST_BIT]   = srst_q;
    ctrl_view[CTRL_LOOPBACK_BIT]   = loopback_q;
    ctrl_view[CTRL_SPEED_BIT]      = speed_q;
    ctrl_view[CTRL_AN_EN_BIT]      = an_en_q;
    ctrl_view[CTRL_PWR_DOWN_BIT]   = pdn_q;
    ctrl_view[CTRL_AN_RESTART_BIT] = restart_q;
    ctrl_view[CTRL_DUPLEX_BIT]     = duplex_q;
    ctrl_view[CTRL_COL_TEST_BIT]   = col_test_q;
    stat_view = STAT_FIXED_VAL;
    stat_view[STAT_AN_DONE_BIT]    = an_done_in;
    stat_view[STAT_LINK_BIT]       = link_ll_q;
  end

  // Read multiplexer; unknown indexes read as zero
  always_comb begin
    unique case (mgmt_idx_in)
      IDX_BASIC_CTRL:     rd_mux = ctrl_view;
      IDX_BASIC_STATUS:   rd_mux = stat_view;
      IDX_IDENT_HIGH:     rd_mux = idh_q;
      IDX_IDENT_LOW:      rd_mux = idl_q;
      IDX_AN_ADVERTISE:   rd_mux = adv_q;
      IDX_AN_PARTNER:     rd_mux = an_partner_in;
      IDX_ENERGY_XOVER:   rd_mux = xover_q;
      IDX_MODE_CTRL_STAT: rd_mux = mode_q;
      IDX_SPECIAL_MODES:  rd_mux = smodes_q;
      IDX_IRQ_MASK:       rd_mux = imask_q;
      IDX_PHY_SPECIAL:    rd_mux = pspec_q;
      default:            rd_mux = 16'h0000;
    endcase
  end

  // Read answer registered one cycle after the request
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mgmt_rd_data_out  <= 16'h0000;
      mgmt_rd_valid_out <= 1'b0;
      mgmt_unmapped_out <= 1'b0;
    end else begin
      mgmt_rd_data_out  <= mgmt_rd_in ? rd_mux : 16'h0000;
      mgmt_rd_valid_out <= mgmt_rd_in;
      mgmt_unmapped_out <= (mgmt_rd_in || mgmt_wr_in) && !idx_hit;
    end
  end

  // Operating outputs; negotiated results override the manual bits
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      soft_rst_busy_out <= 1'b0;
      an_restart_out    <= 1'b0;
      an_enable_out     <= 1'b0;
      speed_100_out     <= 1'b0;
      full_duplex_out   <= 1'b0;
      loopback_out      <= 1'b0;
      power_down_out    <= 1'b0;
      col_test_out      <= 1'b0;
    end else begin
      soft_rst_busy_out <= srst_q;
      an_restart_out    <= restart_q;
      an_enable_out     <= an_en_q;
      speed_100_out     <= an_en_q ? an_speed_100_in : speed_q;
      full_duplex_out   <= an_en_q ? an_full_duplex_in : duplex_q;
      loopback_out      <= loopback_q;
      power_down_out    <= pdn_q;
      col_test_out      <= col_test_q;
    end
  end

  // Counts soft reset cycles; a repetition of the full length would unroll too far
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || !srst_q) begin
      srst_len_q <= 16'h0000;
    end else begin
      srst_len_q <= srst_len_q + 16'h0001;
    end
  end

  // Soft reset ends exactly after the configured count
  soft_rst_len_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $fell(srst_q) |-> srst_len_q == 16'(SOFT_CYCLES))
    else $error("soft reset length wrong");

  // Soft reset never runs past the configured count
  soft_rst_max_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    srst_q |-> srst_len_q < 16'(SOFT_CYCLES))
    else $error("soft reset runs too long");

  // After soft reset the control bits are back at normal mode
  soft_rst_norm_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $fell(srst_q) |-> !loopback_q && !pdn_q && an_en_q && speed_q)
    else $error("not in normal mode after soft reset");

  // Kept field is unchanged across a soft reset
  keep_soft_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    soft_clr |=> smodes_q == $past(smodes_q))
    else $error("kept field lost in soft reset");

  // Manual speed used only when negotiation is off
  speed_sel_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !an_en_q && !$past(sys_rst_in) |=> speed_100_out == $past(speed_q))
    else $error("manual speed not applied");

  // Negotiated duplex used while negotiation is on
  an_override_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    an_en_q |=> full_duplex_out == $past(an_full_duplex_in))
    else $error("negotiated duplex not applied");

  // Power down write reaches the output two cycles later
  pdn_follow_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ctrl_wr && !mgmt_wr_data_in[CTRL_SOFT_RST_BIT]
      |-> ##2 power_down_out == $past(mgmt_wr_data_in[CTRL_PWR_DOWN_BIT], 2))
    else $error("power down output wrong");

  // Restart pulse is one cycle wide unless the bit is written again in the next cycle
  restart_pulse_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ctrl_wr && mgmt_wr_data_in[CTRL_AN_RESTART_BIT] |-> ##2 an_restart_out ##1
      (!an_restart_out || $past(ctrl_wr && mgmt_wr_data_in[CTRL_AN_RESTART_BIT], 2)))
    else $error("restart pulse wrong");

  // Loopback and collision test follow their written bits
  loop_col_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ctrl_wr && !mgmt_wr_data_in[CTRL_SOFT_RST_BIT] |-> ##2
      loopback_out == $past(mgmt_wr_data_in[CTRL_LOOPBACK_BIT], 2) &&
      col_test_out == $past(mgmt_wr_data_in[CTRL_COL_TEST_BIT], 2))
    else $error("loopback or collision test wrong");

  // Unmapped reads answer zero and flag it
  unmapped_rd_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    mgmt_rd_in && !idx_hit |=> mgmt_rd_valid_out && mgmt_unmapped_out
      && mgmt_rd_data_out == 16'h0000)
    else $error("unmapped read not zero");
endmodule : pbcb_bank

// File: rtl/pbcb_pkg.sv
package pbcb_pkg;
  // Register indexes carried through the management access path
  localparam logic [4:0]  IDX_BASIC_CTRL      = 5'h00;
  localparam logic [4:0]  IDX_BASIC_STATUS    = 5'h01;
  localparam logic [4:0]  IDX_IDENT_HIGH      = 5'h02;
  localparam logic [4:0]  IDX_IDENT_LOW       = 5'h03;
  localparam logic [4:0]  IDX_AN_ADVERTISE    = 5'h04;
  localparam logic [4:0]  IDX_AN_PARTNER      = 5'h05;
  localparam logic [4:0]  IDX_AN_EXPANSION    = 5'h06;
  localparam logic [4:0]  IDX_ENERGY_XOVER    = 5'h10;
  localparam logic [4:0]  IDX_MODE_CTRL_STAT  = 5'h11;
  localparam logic [4:0]  IDX_SPECIAL_MODES   = 5'h12;
  localparam logic [4:0]  IDX_SYMBOL_ERRORS   = 5'h1A;
  localparam logic [4:0]  IDX_SPECIAL_INDIC   = 5'h1B;
  localparam logic [4:0]  IDX_IRQ_SOURCE      = 5'h1D;
  localparam logic [4:0]  IDX_IRQ_MASK        = 5'h1E;
  localparam logic [4:0]  IDX_PHY_SPECIAL     = 5'h1F;

  // Basic control field positions
  localparam int unsigned CTRL_SOFT_RST_BIT   = 15;
  localparam int unsigned CTRL_LOOPBACK_BIT   = 14;
  localparam int unsigned CTRL_SPEED_BIT      = 13;
  localparam int unsigned CTRL_AN_EN_BIT      = 12;
  localparam int unsigned CTRL_PWR_DOWN_BIT   = 11;
  localparam int unsigned CTRL_AN_RESTART_BIT = 9;
  localparam int unsigned CTRL_DUPLEX_BIT     = 8;
  localparam int unsigned CTRL_COL_TEST_BIT   = 7;

  // Basic status field positions
  localparam int unsigned STAT_AN_DONE_BIT    = 5;
  localparam int unsigned STAT_LINK_BIT       = 2;

  // Reset values
  localparam logic [15:0] CTRL_RST_VAL        = 16'h3000;
  localparam logic [15:0] STAT_FIXED_VAL      = 16'h7809;
  localparam logic [15:0] ADVERTISE_RST_VAL   = 16'h01E1;
  localparam logic [15:0] ZERO_RST_VAL        = 16'h0000;
  // Writable bits of the advertisement register
  localparam logic [15:0] ADVERTISE_WMASK     = 16'h2FE0;
  localparam logic [15:0] FULL_WMASK          = 16'hFFFF;

  // Timing: soft reset duration
  localparam int unsigned CLK_PERIOD_NS       = 100;
  localparam int unsigned SOFT_RST_NS         = 1000;
  localparam int unsigned SOFT_RST_CYCLES     =
    (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : pbcb_pkg

// File: rtl/pbcb_reg16.sv
// One 16-bit management register with write mask and soft reset policy
module pbcb_reg16 #(
  parameter logic [15:0] RST_VAL   = 16'h0000,
  parameter logic [15:0] WMASK     = 16'hFFFF,
  parameter bit          KEEP_SOFT = 1'b0
) (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        soft_clr_in,
  input  wire logic        wr_in,
  input  wire logic [15:0] wr_data_in,
  output logic      [15:0] value_out
);
  // Hard reset always restores; soft reset only if field is not kept
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      value_out <= RST_VAL;
    end else if (soft_clr_in && !KEEP_SOFT) begin
      value_out <= RST_VAL;
    end else if (wr_in) begin
      // Masked bits are read-only and keep their value
      value_out <= (value_out & ~WMASK) | (wr_data_in & WMASK);
    end
  end
endmodule : pbcb_reg16

// File: testbench/pbcb_mac_model.sv
// MAC-side management master: every register access goes by index
module pbcb_mac_model (
  input  wire logic        clk_in,
  input  wire logic [15:0] rd_data_in,
  input  wire logic        rd_valid_in,
  input  wire logic        unmapped_in,
  output logic             wr_out,
  output logic             rd_out,
  output logic      [4:0]  idx_out,
  output logic      [15:0] wr_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import pbcb_pkg::*;

  // Idle bus at time zero
  initial begin
    wr_out      = 1'b0;
    rd_out      = 1'b0;
    idx_out     = 5'h00;
    wr_data_out = 16'h0000;
  end

  // One write; index and data turn over afterwards, never left showing stale values
  task automatic write_reg(input logic [4:0] idx, input logic [15:0] data);
    @(posedge clk_in);
    wr_out      <= 1'b1;
    idx_out     <= idx;
    wr_data_out <= data;
    @(posedge clk_in);
    wr_out      <= 1'b0;
    idx_out     <= ~idx;
    wr_data_out <= ~data;
  endtask : write_reg

  // One read; the answer stands a single cycle after the taking edge
  task automatic read_reg(input logic [4:0] idx, output logic [15:0] data,
                          output logic valid, output logic unm);
    @(posedge clk_in);
    rd_out  <= 1'b1;
    idx_out <= idx;
    @(posedge clk_in);
    rd_out  <= 1'b0;
    idx_out <= ~idx;
    #1;
    data  = rd_data_in;
    valid = rd_valid_in;
    unm   = unmapped_in;
  endtask : read_reg

  // Soft reset is requested with every other control bit at zero
  task automatic soft_reset();
    write_reg(IDX_BASIC_CTRL, 16'h8000);
  endtask : soft_reset

  // Negotiation is switched off before power down is requested
  task automatic power_down(input logic [15:0] ctrl);
    write_reg(IDX_BASIC_CTRL, ctrl & ~16'h1000);
    write_reg(IDX_BASIC_CTRL, (ctrl & ~16'h1000) | 16'h0800);
  endtask : power_down
endmodule : pbcb_mac_model

// File: testbench/test_phy_basic_control_bank.sv
// Self-checking bench for the PHY management register bank
module test_phy_basic_control_bank;
  timeunit 1ns;
  timeprecision 1ns;
  import pbcb_pkg::*;

  localparam logic [15:0] IDH = 16'h0A5C;  // Arbitrary identity value
  localparam logic [15:0] IDL = 16'h3C96;  // Arbitrary identity value

  logic        clk_in;           // 10 MHz clock
  logic        sys_rst_in;       // Synchronous reset
  logic        mgmt_wr, mgmt_rd; // Strobes from the MAC model
  logic [4:0]  mgmt_idx;         // Register index
  logic [15:0] mgmt_wdata;       // Write data
  logic        link_up, an_done, an_spd, an_dup;  // PHY core levels
  logic [15:0] an_partner;       // Partner ability word
  logic [15:0] rd_data;          // Read answer
  logic        rd_valid, unmapped, busy, restart;
  logic        an_en, spd, dup, loopb, pwrdn, colt;
  logic [15:0] d;                // Last read data
  logic        v, u;             // Last read valid and unmapped flag
  int          n_errors, n_compared, n_restart, k;

  pbcb_bank #(.IDENT_HIGH_VAL(IDH), .IDENT_LOW_VAL(IDL), .SOFT_CYCLES(SOFT_RST_CYCLES))
  pbcb_bank_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .mgmt_wr_in(mgmt_wr), .mgmt_rd_in(mgmt_rd),
    .mgmt_idx_in(mgmt_idx), .mgmt_wr_data_in(mgmt_wdata), .link_up_in(link_up),
    .an_done_in(an_done), .an_speed_100_in(an_spd), .an_full_duplex_in(an_dup),
    .an_partner_in(an_partner), .mgmt_rd_data_out(rd_data), .mgmt_rd_valid_out(rd_valid),
    .mgmt_unmapped_out(unmapped), .soft_rst_busy_out(busy), .an_restart_out(restart),
    .an_enable_out(an_en), .speed_100_out(spd), .full_duplex_out(dup),
    .loopback_out(loopb), .power_down_out(pwrdn), .col_test_out(colt)
  );

  pbcb_mac_model pbcb_mac_model_i (
    .clk_in(clk_in), .rd_data_in(rd_data), .rd_valid_in(rd_valid),
    .unmapped_in(unmapped), .wr_out(mgmt_wr), .rd_out(mgmt_rd),
    .idx_out(mgmt_idx), .wr_data_out(mgmt_wdata)
  );

  // Clock generation
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // Counts cycles with the restart pulse high, so a stretched pulse shows up
  always @(posedge clk_in) begin
    if (restart === 1'b1) begin
      n_restart++;
    end
  end

  // Word comparison
  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk16

  // Operating levels as {an_en, speed, duplex, loopback, power_down, col_test}
  task automatic chk_modes(input logic [5:0] exp);
    repeat (3) @(posedge clk_in);
    #1;
    chk16("modes", {10'h000, exp}, {10'h000, an_en, spd, dup, loopb, pwrdn, colt});
  endtask : chk_modes

  // Read one register and compare data, valid and unmapped flag
  task automatic rd_chk(input logic [4:0] idx, input logic [15:0] exp);
    pbcb_mac_model_i.read_reg(idx, d, v, u);
    chk16("read data", exp, d);
    chk16("read valid", 16'h0001, {15'h0000, v});
    chk16("unmapped", 16'h0000, {15'h0000, u});
  endtask : rd_chk

  // Synchronous reset held for three edges
  task automatic hard_reset();
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'b0;
  endtask : hard_reset

  // Prints the counts and the verdict, then stops
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  // Main sequence
  initial begin
    n_errors = 0;
    n_compared = 0;
    n_restart = 0;
    sys_rst_in = 1'b1;
    link_up = 1'b0;
    an_done = 1'b0;
    an_spd = 1'b0;
    an_dup = 1'b0;
    an_partner = 16'hC3A5;
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd_chk(IDX_BASIC_CTRL, CTRL_RST_VAL);
    rd_chk(IDX_BASIC_STATUS, STAT_FIXED_VAL);
    rd_chk(IDX_IDENT_HIGH, IDH);
    rd_chk(IDX_IDENT_LOW, IDL);
    rd_chk(IDX_AN_PARTNER, 16'hC3A5);
    chk_modes(6'b100000);
    // Every index: only the decoded set answers without the unmapped flag
    for (int i = 0; i < 32; i++) begin
      pbcb_mac_model_i.read_reg(5'(i), d, v, u);
      k = int'(i <= 6 || (i >= 16 && i <= 18) || i == 26 || i == 27 || i >= 29);
      chk16("unmapped", {15'h0000, k == 0}, {15'h0000, u});
      if (k == 0) begin
        chk16("unmapped data", 16'h0000, d);
      end
    end
    // Negotiated results win while negotiation is on
    an_spd <= 1'b1;
    an_dup <= 1'b1;
    chk_modes(6'b111000);
    pbcb_mac_model_i.write_reg(IDX_BASIC_CTRL, 16'h3100);
    an_spd <= 1'b0;
    an_dup <= 1'b0;
    chk_modes(6'b100000);
    pbcb_mac_model_i.write_reg(IDX_BASIC_CTRL, 16'h2100);
    chk_modes(6'b011000);
    pbcb_mac_model_i.write_reg(IDX_BASIC_CTRL, 16'h0000);
    chk_modes(6'b000000);
    pbcb_mac_model_i.power_down(16'h1000);
    chk_modes(6'b000010);
    rd_chk(IDX_BASIC_CTRL, 16'h0800);
    pbcb_mac_model_i.write_reg(IDX_BASIC_CTRL, 16'h0000);
    chk_modes(6'b000000);
    // Reserved bits do not stick
    pbcb_mac_model_i.write_reg(IDX_BASIC_CTRL, 16'h44FF);
    rd_chk(IDX_BASIC_CTRL, 16'h4080);
    chk_modes(6'b000101);
    // Restart gives one pulse and self-clears; writing zero gives none
    pbcb_mac_model_i.write_reg(IDX_BASIC_CTRL, 16'h1200);
    chk_modes(6'b100000);
    chk16("restart pulses", 16'h0001, 16'(n_restart));
    rd_chk(IDX_BASIC_CTRL, 16'h1000);
    pbcb_mac_model_i.write_reg(IDX_BASIC_CTRL, 16'h1000);
    chk_modes(6'b100000);
    chk16("restart pulses", 16'h0001, 16'(n_restart));
    // Soft reset: kept fields survive, the rest return to defaults
    pbcb_mac_model_i.write_reg(IDX_AN_ADVERTISE, 16'hFFFF);
    rd_chk(IDX_AN_ADVERTISE, ADVERTISE_WMASK | (ADVERTISE_RST_VAL & ~ADVERTISE_WMASK));
    pbcb_mac_model_i.write_reg(IDX_SPECIAL_MODES, 16'h00AB);
    pbcb_mac_model_i.write_reg(IDX_BASIC_CTRL, 16'h4000);
    pbcb_mac_model_i.soft_reset();
    pbcb_mac_model_i.read_reg(IDX_BASIC_CTRL, d, v, u);
    chk16("soft reset bit", 16'h0001, {15'h0000, d[CTRL_SOFT_RST_BIT]});
    chk16("soft reset busy", 16'h0001, {15'h0000, busy});
    pbcb_mac_model_i.write_reg(IDX_BASIC_CTRL, 16'h4800);
    k = 0;
    while (busy !== 1'b0) begin
      if (k == 4 * SOFT_RST_CYCLES + 20) begin
        n_errors++;
        $display("MISMATCH soft reset end expected 0 seen 1");
        end_sim();
      end
      k++;
      @(posedge clk_in);
      #1;
    end
    rd_chk(IDX_BASIC_CTRL, CTRL_RST_VAL);
    chk_modes(6'b100000);
    rd_chk(IDX_AN_ADVERTISE, ADVERTISE_RST_VAL);
    rd_chk(IDX_SPECIAL_MODES, 16'h00AB);
    hard_reset();
    rd_chk(IDX_SPECIAL_MODES, ZERO_RST_VAL);
    // Link bit latches low: the second read shows the live state
    link_up <= 1'b1;
    an_done <= 1'b1;
    pbcb_mac_model_i.read_reg(IDX_BASIC_STATUS, d, v, u);
    chk16("latched link", STAT_FIXED_VAL | 16'h0020, d);
    rd_chk(IDX_BASIC_STATUS, STAT_FIXED_VAL | 16'h0024);
    end_sim();
  end
endmodule : test_phy_basic_control_bank
